// [ebam_lane_map.v]
`timescale 1ns/1ps
`default_nettype none
`include "ebam_regs.vh"

// Operation
// [R1] Decode control group at fixed peripheral addresses
// [R2] Per-bank width field steers address generation
// [R3] I/O bank window capped at 4M bytes
// [R4] Address pins from bits 20:0 or 21:1; the code also drives them from bits 22:2 for 32-bit banks
// [R5] Byte-order strap: high little, low big
// [R6] Little endian: byte 0 on lanes 7:0
// [R7] Big endian: byte 0 on lanes 31:24
// [R8] Abort on access outside every bank; the code also spares control group addresses from the abort
// [R9] Strap latched once at reset end

module ebam_lane_map (
  // Clock and reset
  input  wire                                    ref_clk,
  input  wire                                    sys_rst,
  // Byte order strap on external data line 14
  input  wire                                    byte_order_strap_line,
  // Internal access request
  input  wire                                    req_valid,
  input  wire [31:0]                             req_addr,
  input  wire [1:0]                              req_size,
  input  wire [31:0]                             req_wdata,
  // Bank setup, bank 0 boot, banks 1 to 4 external I/O
  input  wire [`EBAM_NUM_BANKS*`EBAM_PTR_W-1:0]  bank_base_ptr,
  input  wire [`EBAM_NUM_BANKS*`EBAM_SIZE_W-1:0] bank_size_code,
  input  wire [`EBAM_NUM_BANKS*`EBAM_BW_W-1:0]   bank_bus_width_field,
  // Decode result
  output reg                                     resp_valid,
  output reg                                     resp_abort,
  output reg  [`EBAM_NUM_BANKS-1:0]              ext_bank_sel,
  output reg  [`EBAM_XA_W-1:0]                   ext_addr,
  output reg  [3:0]                              ctl_grp_sel,
  output reg  [3:0]                              lane_sel,
  output reg  [31:0]                             lane_wdata,
  // Byte order in force
  output wire                                    little_endian
);

  // --------------------------------------------------------------------
  // Byte order strap capture
  // --------------------------------------------------------------------
  reg                         strap_done_reg;
  reg                         little_reg;

  // First edge after reset release takes the strap, then holds
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_done_reg <= 1'b0;
      little_reg     <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1; // [R9]
      little_reg     <= byte_order_strap_line; // [R5]
    end
  end

  assign little_endian = little_reg;

  // --------------------------------------------------------------------
  // Bank windows
  // --------------------------------------------------------------------
  wire [`EBAM_NUM_BANKS-1:0]  bank_hit;
  wire [`EBAM_XA_W-1:0]       bank_xa [0:`EBAM_NUM_BANKS-1];

  genvar g;
  generate
    for (g = 0; g < `EBAM_NUM_BANKS; g = g + 1) begin : g_bank
      ebam_bank_win u_win (
        .addr                 (req_addr),
        .base_ptr             (bank_base_ptr[g*`EBAM_PTR_W +:
                                             `EBAM_PTR_W]),
        .size_code            (bank_size_code[g*`EBAM_SIZE_W +:
                                              `EBAM_SIZE_W]),
        .bank_bus_width_field (bank_bus_width_field[g*`EBAM_BW_W +:
                                                    `EBAM_BW_W]), // [R2]
        .is_io_bank           (g != 0),
        .hit                  (bank_hit[g]),
        .xa                   (bank_xa[g])
      );
    end
  endgenerate

  // Lowest numbered hit wins; windows must not overlap anyway
  reg  [`EBAM_NUM_BANKS-1:0]  sel_next;
  reg  [`EBAM_XA_W-1:0]       xa_next;
  integer i;

  always @* begin
    sel_next = {`EBAM_NUM_BANKS{1'b0}};
    xa_next  = `EBAM_XA_RST;
    for (i = `EBAM_NUM_BANKS - 1; i >= 0; i = i - 1) begin
      if (bank_hit[i]) begin
        sel_next    = {`EBAM_NUM_BANKS{1'b0}};
        sel_next[i] = 1'b1;
        xa_next     = bank_xa[i];
      end
    end
  end

  // --------------------------------------------------------------------
  // Control register group decode
  // --------------------------------------------------------------------
  reg  [3:0]                  grp_next;
  wire                        in_grp_base;
  wire                        in_boot_ctl;
  wire                        in_sdram_ctl;
  wire                        in_io_ctl;

  // Address windows of the four control sub-groups
  assign in_grp_base  = (req_addr >= `EBAM_GRP_BASE) &&
                        (req_addr < `EBAM_BOOT_CTL);
  assign in_boot_ctl  = (req_addr >= `EBAM_BOOT_CTL) &&
                        (req_addr < `EBAM_SDRAM_CTL);
  assign in_sdram_ctl = (req_addr >= `EBAM_SDRAM_CTL) &&
                        (req_addr < `EBAM_IO_CTL);
  assign in_io_ctl    = (req_addr >= `EBAM_IO_CTL) &&
                        (req_addr < `EBAM_GRP_END);

  // One-hot select of the claimed sub-group
  always @* begin
    grp_next = 4'h0;
    if (in_io_ctl) begin
      grp_next[`EBAM_SEL_IO] = 1'b1; // [R1]
    end else if (in_sdram_ctl) begin
      grp_next[`EBAM_SEL_SDRAM] = 1'b1; // [R1]
    end else if (in_boot_ctl) begin
      grp_next[`EBAM_SEL_BOOT] = 1'b1; // [R1]
    end else if (in_grp_base) begin
      grp_next[`EBAM_SEL_GRP] = 1'b1; // [R1]
    end
  end

  // --------------------------------------------------------------------
  // Byte lane mapping
  // --------------------------------------------------------------------
  reg  [3:0]                  lane_next;
  reg  [31:0]                 wdata_next;
  reg  [1:0]                  lane_idx;

  // Internal lane of the addressed byte follows the byte order
  always @* begin
    if (little_reg) begin
      lane_idx = req_addr[1:0]; // [R6]
    end else begin
      lane_idx = 2'h3 - req_addr[1:0]; // [R7]
    end
  end

  // Lane enables and write data placed onto those lanes
  always @* begin
    lane_next  = 4'hF;
    wdata_next = req_wdata;
    case (req_size)
      `EBAM_SZ_BYTE: begin
        lane_next  = 4'h1 << lane_idx;
        wdata_next = {4{req_wdata[7:0]}};
      end
      `EBAM_SZ_HALF: begin
        if (req_addr[1] == little_reg) begin
          lane_next = 4'hC; // [R6] [R7]
        end else begin
          lane_next = 4'h3;
        end
        wdata_next = {2{req_wdata[15:0]}};
      end
      default: begin
        lane_next  = 4'hF;
        wdata_next = req_wdata;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Registered response
  // --------------------------------------------------------------------
  wire                        bank_any;
  wire                        grp_any;
  wire                        miss;

  // A request is claimed by a bank window or by the control group
  assign bank_any = |sel_next;
  assign grp_any  = |grp_next;
  assign miss     = !bank_any && !grp_any; // [R8]

  // Pulse outputs, one cycle per taken request
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      resp_valid <= 1'b0;
      resp_abort <= 1'b0;
    end else begin
      resp_valid <= req_valid;
      resp_abort <= req_valid && miss; // [R8]
    end
  end

  // Bank select and address pins, held until the next request
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_bank_sel <= {`EBAM_NUM_BANKS{1'b0}};
      ext_addr     <= `EBAM_XA_RST;
      ctl_grp_sel  <= 4'h0;
    end else if (req_valid) begin
      ext_bank_sel <= sel_next;
      ext_addr     <= xa_next; // [R2] [R4]
      ctl_grp_sel  <= grp_next; // [R1]
    end
  end

  // Lane enables and write data, lanes dropped on a miss
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lane_sel   <= `EBAM_LANE_RST;
      lane_wdata <= 32'h0000_0000;
    end else if (req_valid) begin
      lane_sel   <= miss ? `EBAM_LANE_RST : lane_next; // [R8]
      lane_wdata <= wdata_next;
    end
  end

endmodule // ebam_lane_map
`default_nettype wire

// [ebam_regs.vh]
`ifndef EBAM_REGS_VH
`define EBAM_REGS_VH

// ----------------------------------------------------------------------
// Control register group addresses
// ----------------------------------------------------------------------
`define EBAM_GRP_BASE      32'hFFF0_1000
`define EBAM_BOOT_CTL      32'hFFF0_1004
`define EBAM_SDRAM_CTL     32'hFFF0_1008
`define EBAM_IO_CTL        32'hFFF0_1018
`define EBAM_GRP_END       32'hFFF0_1028

// ----------------------------------------------------------------------
// Control group select bit positions
// ----------------------------------------------------------------------
`define EBAM_SEL_GRP       0
`define EBAM_SEL_BOOT      1
`define EBAM_SEL_SDRAM     2
`define EBAM_SEL_IO        3

// ----------------------------------------------------------------------
// Bank window geometry
// ----------------------------------------------------------------------
`define EBAM_NUM_BANKS     5
`define EBAM_PTR_W         13
`define EBAM_PTR_SHIFT     18
`define EBAM_SIZE_W        3
`define EBAM_SIZE_UNIT     32'h0004_0000
`define EBAM_IO_SIZE_MAX   3'h4
`define EBAM_XA_W          21

// ----------------------------------------------------------------------
// Bank bus width field encodings
// ----------------------------------------------------------------------
`define EBAM_BW_W          2
`define EBAM_BW_8          2'h0
`define EBAM_BW_16         2'h1
`define EBAM_BW_32         2'h2

// ----------------------------------------------------------------------
// Access size encodings
// ----------------------------------------------------------------------
`define EBAM_SZ_BYTE       2'h0
`define EBAM_SZ_HALF       2'h1
`define EBAM_SZ_WORD       2'h2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define EBAM_XA_RST        21'h00_0000
`define EBAM_LANE_RST      4'h0

`endif

// [ebam_bank_win.v]
`timescale 1ns/1ps
`default_nettype none
`include "ebam_regs.vh"

module ebam_bank_win (
  // Incoming access
  input  wire [31:0]                 addr,
  // Bank setup
  input  wire [`EBAM_PTR_W-1:0]      base_ptr,
  input  wire [`EBAM_SIZE_W-1:0]     size_code,
  input  wire [`EBAM_BW_W-1:0]       bank_bus_width_field,
  input  wire                        is_io_bank,
  // Decode result
  output wire                        hit,
  output reg  [`EBAM_XA_W-1:0]       xa
);

  wire [31:0]               base;
  wire [31:0]               offset;
  wire [`EBAM_SIZE_W-1:0]   eff_code;
  wire [31:0]               win_size;

  // Window start and size, I/O banks capped at 4M bytes
  assign base     = {1'b0, base_ptr, {`EBAM_PTR_SHIFT{1'b0}}};
  assign eff_code = (is_io_bank && (size_code > `EBAM_IO_SIZE_MAX)) ?
                    `EBAM_IO_SIZE_MAX : size_code; // [R3]
  assign win_size = `EBAM_SIZE_UNIT << eff_code;
  assign offset   = addr - base;
  assign hit      = (addr >= base) && (offset < win_size);

  // Address pins shifted by the bank data width
  always @* begin
    if (bank_bus_width_field == `EBAM_BW_8) begin
      xa = addr[20:0]; // [R4]
    end else if (bank_bus_width_field == `EBAM_BW_16) begin
      xa = addr[21:1]; // [R4]
    end else begin
      xa = addr[22:2];
    end
  end

endmodule // ebam_bank_win
`default_nettype wire

// [ebam_strap_board.sv]
`timescale 1ns/1ps
`default_nettype none
// Board strap resistor on data line 14
module ebam_strap_board (
  // Strap choice and pin
  input  wire logic pull_up,
  output wire logic byte_order_strap_line
);
  // Resistor level held through reset, high little, low big
  assign byte_order_strap_line = pull_up;
endmodule // ebam_strap_board
`default_nettype wire

// [ebam_lane_map_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module ebam_lane_map_checker (
  // Clock, reset and request
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        req_valid,
  input wire logic [31:0] req_addr,
  input wire logic [1:0]  req_size,
  // Decode result
  input wire logic        resp_valid,
  input wire logic        resp_abort,
  input wire logic [4:0]  ext_bank_sel,
  input wire logic [3:0]  ctl_grp_sel,
  input wire logic [3:0]  lane_sel,
  input wire logic        little_endian
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Response that landed in a bank window
  wire bank_ok = resp_valid && ext_bank_sel != 5'h00;
  chk_resp_next: assert property (req_valid |=> resp_valid)
    else $error("response missing after request");
  chk_no_spur: assert property (!req_valid |=> !resp_valid)
    else $error("response without request");
  chk_abort_clear: assert property (resp_abort |-> resp_valid
    && ext_bank_sel == 5'h00 && lane_sel == 4'h0 && ctl_grp_sel == 4'h0)
    else $error("abort with selects active");
  chk_sel_onehot: assert property ($onehot0(ext_bank_sel)
    && $onehot0(ctl_grp_sel)) else $error("select not one-hot");
  chk_boot_grp: assert property (req_valid
    && req_addr == 32'hFFF0_1004 |=> ctl_grp_sel == 4'h2)
    else $error("boot control group not selected");
  chk_order_held: assert property (!$past(sys_rst)
    && !$past(sys_rst, 2) |-> $stable(little_endian))
    else $error("byte order moved");
  chk_word_lane: assert property (bank_ok && $past(req_size) == 2'h2
    |-> lane_sel == 4'hF) else $error("word lanes wrong");
  chk_le_byte: assert property (bank_ok && little_endian
    && $past(req_size) == 2'h0 |-> lane_sel == 4'h1 << $past(req_addr[1:0]))
    else $error("little byte lane wrong");
  chk_be_byte: assert property (bank_ok && !little_endian
    && $past(req_size) == 2'h0 |-> lane_sel == 4'h8 >> $past(req_addr[1:0]))
    else $error("big byte lane wrong");
  // Main scenarios seen
  cov_abort: cover property (resp_abort);
  cov_le_bank: cover property (bank_ok && little_endian);
  cov_be_bank: cover property (bank_ok && !little_endian);
endmodule // ebam_lane_map_checker
bind ebam_lane_map ebam_lane_map_checker u_chk (
  .ref_clk       (ref_clk),
  .sys_rst       (sys_rst),
  .req_valid     (req_valid),
  .req_addr      (req_addr),
  .req_size      (req_size),
  .resp_valid    (resp_valid),
  .resp_abort    (resp_abort),
  .ext_bank_sel  (ext_bank_sel),
  .ctl_grp_sel   (ctl_grp_sel),
  .lane_sel      (lane_sel),
  .little_endian (little_endian)
);
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  // Stimulus, bank 0 boot 2M 8-bit, bank 1 I/O code 7 16-bit
  logic        ref_clk = 1'b0, sys_rst = 1'b1, pull_up = 1'b1;
  logic        req_valid = 1'b0;
  logic [31:0] req_addr = 32'h0000_0000, req_wdata = 32'h0000_0000;
  logic [1:0]  req_size = 2'h0;
  logic [64:0] bank_base_ptr = {13'h0102, 13'h0101, 13'h0100, 13'h0010,
                                13'h0000};
  logic [14:0] bank_size_code = {3'h0, 3'h0, 3'h0, 3'h7, 3'h3};
  logic [9:0]  bank_bus_width_field = {2'h2, 2'h2, 2'h2, 2'h1, 2'h0};
  wire         byte_order_strap_line, resp_valid, resp_abort, little_endian;
  wire [4:0]   ext_bank_sel;
  wire [20:0]  ext_addr;
  wire [3:0]   ctl_grp_sel, lane_sel;
  wire [31:0]  lane_wdata;
  int          err_count = 0, total_checks = 0, cyc = 0;
  ebam_strap_board u_board (.pull_up(pull_up),
    .byte_order_strap_line(byte_order_strap_line));
  ebam_lane_map u_dut (
    .ref_clk               (ref_clk),
    .sys_rst               (sys_rst),
    .byte_order_strap_line (byte_order_strap_line),
    .req_valid             (req_valid),
    .req_addr              (req_addr),
    .req_size              (req_size),
    .req_wdata             (req_wdata),
    .bank_base_ptr         (bank_base_ptr),
    .bank_size_code        (bank_size_code),
    .bank_bus_width_field  (bank_bus_width_field),
    .resp_valid            (resp_valid),
    .resp_abort            (resp_abort),
    .ext_bank_sel          (ext_bank_sel),
    .ext_addr              (ext_addr),
    .ctl_grp_sel           (ctl_grp_sel),
    .lane_sel              (lane_sel),
    .lane_wdata            (lane_wdata),
    .little_endian         (little_endian)
  );
  always #2.5 ref_clk = ~ref_clk;
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      end_of_test;
    end
  end
  task automatic end_of_test;
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  // One request, returns at the falling edge inside the response cycle
  task automatic req(input logic [31:0] a, input logic [1:0] s);
    @(negedge ref_clk);
    req_valid = 1'b1;
    req_addr = a;
    req_size = s;
    req_wdata = ~a;
    @(negedge ref_clk);
    req_valid = 1'b0;
  endtask
  task automatic t_strap(input logic p);
    pull_up = p;
    sys_rst = 1'b1;
    repeat (6) @(negedge ref_clk);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    pull_up = ~p;
    repeat (3) @(negedge ref_clk);
    chk("byte order", p, little_endian);
  endtask
  task automatic t_width;
    req(32'h0012_3457, 2'h0);
    chk("valid", 32'h1, resp_valid);
    chk("bank sel", 32'h1, ext_bank_sel);
    chk("addr 8", 32'h0012_3457, ext_addr);
    chk("wdata", 32'hA8A8_A8A8, lane_wdata);
    req(32'h0052_3456, 2'h1);
    chk("bank sel", 32'h2, ext_bank_sel);
    chk("addr 16", 32'h0012_3456 >> 1, ext_addr);
    chk("wdata", 32'hCBA9_CBA9, lane_wdata);
    req(32'h0400_0010, 2'h2);
    chk("bank sel", 32'h4, ext_bank_sel);
    chk("addr 32", 32'h0000_0004, ext_addr);
  endtask
  task automatic t_cap;
    req(32'h007F_FFFC, 2'h2);
    chk("abort", 32'h0, resp_abort);
    req(32'h0080_0000, 2'h2);
    chk("abort", 32'h1, resp_abort);
    req(32'h7000_0000, 2'h0);
    chk("abort", 32'h1, resp_abort);
    chk("miss lane", 32'h0, lane_sel);
  endtask
  task automatic t_group;
    logic [31:0] g [4] = '{32'hFFF0_1000, 32'hFFF0_1004, 32'hFFF0_1008,
                           32'hFFF0_1018};
    for (int i = 0; i < 4; i++) begin
      req(g[i], 2'h2);
      chk("group", 32'h1 << i, ctl_grp_sel);
      chk("abort", 32'h0, resp_abort);
    end
  endtask
  task automatic t_lanes(input logic le);
    for (int i = 0; i < 4; i++) begin
      req(32'h0000_0100 + i, 2'h0);
      chk("byte lane", le ? 4'h1 << i : 4'h8 >> i, lane_sel);
    end
    req(32'h0000_0102, 2'h1);
    chk("half lane", le ? 4'hC : 4'h3, lane_sel);
    req(32'h0000_0100, 2'h1);
    chk("half lane", le ? 4'h3 : 4'hC, lane_sel);
  endtask
  // Main sequence
  initial begin
    t_strap(1'b1);
    t_width;
    t_cap;
    t_group;
    t_lanes(1'b1);
    t_strap(1'b0);
    t_lanes(1'b0);
    end_of_test;
  end
endmodule // tb
`default_nettype wire
